/* File: design/cst_charger_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "cst_charger_map.vh"

// Summary of operation
// - Load-sharing cut or junction over regulation limit counts as current reduction.
// - During current reduction the safety timer ticks at half rate.
// - During current reduction termination detection is suppressed.
// - Full rate and termination return once both reducing causes clear.
// - Half-rate behaviour is on after reset, off when its enable bit is 0.
// - Precharge timeout fault if battery stays below exit threshold too long.
// - Fast-charge timeout fault if termination not reached before timer expiry.
// - Fast-charge time counts from the start of the fast-charge phase.
// - Precharge and fast-charge timeouts show in two separate status bits.
// - Supply rising edge, restart bit or recharge threshold clear faults, restart.
// - Temperature fault is battery hot or cold or thermal shutdown.
// - Temperature fault while charging suspends charge and freezes the timer.
// - Temperature recovery resumes charge and timer without clearing it.
// - A bit selects the 45 C or 60 C upper charge temperature window.
// - Thermistor type bit at 1 selects high-value thermistor thresholds.
// - In sleep charging continues while all configuration returns to default.
// - Timers are off when termination is disabled or timer enable is 0.
// - Current reaching termination threshold sets the termination status bit.

module cst_charger_ctrl #(
  parameter [`CST_TICK_W-1:0] TICK_CYCLES = `CST_TICK_CYCLES
) (
  input wire sys_clk,
  input wire rst_n,
  input wire sleep_state,
  input wire charger_enable,
  input wire [`CST_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire usb_supply_present,
  input wire adapter_supply_present,
  input wire load_sharing_loop,
  input wire thermal_reg_active,
  input wire bat_above_precharge_exit,
  input wire bat_below_recharge,
  input wire current_at_term,
  input wire bat_hot_45,
  input wire bat_hot_60,
  input wire bat_cold,
  input wire thermal_shutdown,
  output reg charge_on,
  output reg fast_charge_on,
  output reg thermistor_high_value,
  output reg temp_fault,
  output reg reduced_current
);
  // =============================================
  // Charge phases.
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_PRE = 2'h1;
  localparam [1:0] PH_FAST = 2'h2;
  localparam [1:0] PH_DONE = 2'h3;

  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  reg [7:0] ctrl_reg;
  reg [7:0] timer_reg;
  reg [7:0] thresh_reg;
  reg term_flag_reg;
  reg pch_tout_reg;
  reg fch_tout_reg;
  reg restart_bit_pulse;
  reg [`CST_MIN_W-1:0] elapsed_reg;
  reg [`CST_MIN_W-1:0] elapsed_next;

  wire usb_rise;
  wire ac_rise;
  wire restart;
  wire hot;
  wire temp_bad;
  wire reducing;
  wire term_disabled;
  wire timers_on;
  wire timer_run;
  wire tick;
  wire [`CST_MIN_W-1:0] pch_limit;
  wire [`CST_MIN_W-1:0] fch_limit;
  wire [7:0] status_word;

  // Converts a 2-bit limit code to minutes.
  function [`CST_MIN_W-1:0] limit_minutes;
    input [1:0] code;
    input is_fast;
    begin
      if (is_fast) begin
        limit_minutes = {2'b00, code, 6'h00} + 10'h078;
      end else begin
        limit_minutes = {4'h0, code, 4'h0} + 10'h01E;
      end
    end
  endfunction

  // =============================================
  // Supply edges.
  cst_edge_detect u_usb_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level_in(usb_supply_present),
    .rise_pulse(usb_rise)
  );

  cst_edge_detect u_ac_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level_in(adapter_supply_present),
    .rise_pulse(ac_rise)
  );

  assign restart = usb_rise | ac_rise | restart_bit_pulse | bat_below_recharge;

  assign hot = thresh_reg[`CST_TH_TEMP_WINDOW_SELECT_BIT] ? bat_hot_60 : bat_hot_45;
  assign temp_bad = hot | bat_cold | thermal_shutdown;
  assign reducing = load_sharing_loop | thermal_reg_active;
  assign term_disabled = ctrl_reg[`CST_CT_TERM_DIS_BIT];
  assign timers_on = ctrl_reg[`CST_CT_SAFETY_TIMER_ENABLE_BIT] & ~term_disabled;
  assign timer_run = timers_on & ~temp_bad & ((phase_reg == PH_PRE) | (phase_reg == PH_FAST));

  assign pch_limit = limit_minutes(thresh_reg[`CST_TH_PCH_LIM_LSB +: 2], 1'b0);
  assign fch_limit = limit_minutes(ctrl_reg[`CST_CT_FCH_LIM_LSB +: 2], 1'b1);

  // =============================================
  // Tick generator.
  // half rate tick
  cst_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(timer_run),
    .half_rate(reducing & timer_reg[`CST_TM_DYN_BIT]),
    .tick(tick)
  );

  // =============================================
  // Configuration registers.
  // sleep defaults
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CST_CTRL_RESET;
      timer_reg <= `CST_TIMER_RESET;
      thresh_reg <= `CST_THRESH_RESET;
      restart_bit_pulse <= 1'b0;
    end else if (sleep_state) begin
      ctrl_reg <= `CST_CTRL_RESET;
      timer_reg <= `CST_TIMER_RESET;
      thresh_reg <= `CST_THRESH_RESET;
      restart_bit_pulse <= 1'b0;
    end else begin
      restart_bit_pulse <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `CST_ADDR_CONTROL: begin
            ctrl_reg <= reg_wdata & 8'hFE;
            restart_bit_pulse <= reg_wdata[`CST_CT_RESTART_BIT];
          end
          `CST_ADDR_TIMER: timer_reg <= reg_wdata & 8'h01;
          `CST_ADDR_THRESH: thresh_reg <= reg_wdata & 8'h31;
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // =============================================
  // Charge phase and safety timer.
  always @* begin
    phase_next = phase_reg;
    elapsed_next = elapsed_reg;
    if (restart) begin
      phase_next = charger_enable ? PH_PRE : PH_IDLE;
      elapsed_next = {`CST_MIN_W{1'b0}};
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (charger_enable & ~pch_tout_reg & ~fch_tout_reg) begin
            phase_next = PH_PRE;
          end
        end
        PH_PRE: begin
          if (bat_above_precharge_exit & ~temp_bad) begin
            phase_next = PH_FAST;
            elapsed_next = {`CST_MIN_W{1'b0}};
          end else if (timers_on & (elapsed_reg >= pch_limit)) begin
            phase_next = PH_DONE;
          end else if (tick) begin
            elapsed_next = elapsed_reg + 1'b1;
          end
        end
        PH_FAST: begin
          if (current_at_term & ~reducing & ~term_disabled & ~temp_bad) begin
            phase_next = PH_DONE;
          end else if (timers_on & (elapsed_reg >= fch_limit)) begin
            phase_next = PH_DONE;
          end else if (tick) begin
            elapsed_next = elapsed_reg + 1'b1;
          end
        end
        PH_DONE: phase_next = PH_DONE;
        default: phase_next = PH_IDLE;
      endcase
      if (~charger_enable) begin
        phase_next = PH_IDLE;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_IDLE;
      elapsed_reg <= {`CST_MIN_W{1'b0}};
      term_flag_reg <= 1'b0;
      pch_tout_reg <= 1'b0;
      fch_tout_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      elapsed_reg <= elapsed_next;
      if (restart) begin
        term_flag_reg <= 1'b0;
        pch_tout_reg <= 1'b0;
        fch_tout_reg <= 1'b0;
      end else begin
        if (phase_reg == PH_PRE && phase_next == PH_DONE) begin
          pch_tout_reg <= 1'b1;
        end
        if (phase_reg == PH_FAST && phase_next == PH_DONE) begin
          if (current_at_term & ~reducing & ~term_disabled & ~temp_bad) begin
            term_flag_reg <= 1'b1;
          end else begin
            fch_tout_reg <= 1'b1;
          end
        end
      end
    end
  end

  // =============================================
  // Outputs and status.
  // full rate return
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_on <= 1'b0;
      fast_charge_on <= 1'b0;
      thermistor_high_value <= 1'b0;
      temp_fault <= 1'b0;
      reduced_current <= 1'b0;
    end else begin
      charge_on <= ((phase_next == PH_PRE) | (phase_next == PH_FAST)) & ~temp_bad;
      fast_charge_on <= (phase_next == PH_FAST) & ~temp_bad;
      thermistor_high_value <= ctrl_reg[`CST_CT_NTC_BIT];
      temp_fault <= temp_bad;
      reduced_current <= reducing;
    end
  end

  assign status_word = {phase_reg, charge_on, reducing, temp_bad, fch_tout_reg, pch_tout_reg, term_flag_reg};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CST_ADDR_STATUS: reg_rdata <= status_word;
        `CST_ADDR_CONTROL: reg_rdata <= ctrl_reg;
        `CST_ADDR_TIMER: reg_rdata <= timer_reg;
        `CST_ADDR_THRESH: reg_rdata <= thresh_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

`default_nettype wire

/* File: design/cst_charger_map.vh */
`ifndef CST_CHARGER_MAP_VH
`define CST_CHARGER_MAP_VH

// Register indices on the plain register port.
`define CST_ADDR_W 4
`define CST_ADDR_STATUS 4'h0
`define CST_ADDR_CONTROL 4'h1
`define CST_ADDR_TIMER 4'h2
`define CST_ADDR_THRESH 4'h3

// Status register fields (read only, flags clear on restart).
`define CST_ST_TERM_BIT 0
`define CST_ST_PCH_TOUT_BIT 1
`define CST_ST_FCH_TOUT_BIT 2
`define CST_ST_TEMP_FAULT_BIT 3
`define CST_ST_REDUCED_BIT 4
`define CST_ST_CHARGING_BIT 5
`define CST_ST_PHASE_LSB 6

// Control register fields.
`define CST_CT_RESTART_BIT 0
`define CST_CT_TERM_DIS_BIT 1
`define CST_CT_SAFETY_TIMER_ENABLE_BIT 2
`define CST_CT_NTC_BIT 3
`define CST_CT_FCH_LIM_LSB 4
`define CST_CTRL_RESET 8'h04

// Timer register fields.
`define CST_TM_DYN_BIT 0
`define CST_TIMER_RESET 8'h01

// Threshold register fields.
`define CST_TH_TEMP_WINDOW_SELECT_BIT 0
`define CST_TH_PCH_LIM_LSB 4
`define CST_THRESH_RESET 8'h00

// Timing: one minute tick of the safety timer at 50 MHz.
`define CST_CLK_HZ 50000000
`define CST_TICK_S 60
`define CST_TICK_W 32
`define CST_TICK_CYCLES 32'hB2D05E00
`define CST_MIN_W 10

`endif

/* File: design/cst_edge_detect.v */
`timescale 1ns/1ps
`default_nettype none

// =============================================
// Rising edge detector for supply-present levels.
module cst_edge_detect (
  input wire sys_clk,
  input wire rst_n,
  input wire level_in,
  output wire rise_pulse
);
  reg level_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_in;
    end
  end

  assign rise_pulse = level_in & ~level_reg;
endmodule

`default_nettype wire

/* File: design/cst_tick_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "cst_charger_map.vh"

// =============================================
// Slow tick source with an optional half-rate mode.
module cst_tick_gen #(
  parameter [`CST_TICK_W-1:0] TICK_CYCLES = `CST_TICK_CYCLES
) (
  input wire sys_clk,
  input wire rst_n,
  input wire run,
  input wire half_rate,
  output reg tick
);
  reg [`CST_TICK_W-1:0] cnt_reg;
  reg phase_reg;

  // The count holds while not running, so a paused timer keeps its place.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {`CST_TICK_W{1'b0}};
      phase_reg <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run) begin
        if (cnt_reg >= TICK_CYCLES - 1'b1) begin
          cnt_reg <= {`CST_TICK_W{1'b0}};
          phase_reg <= ~phase_reg;
          tick <= ~half_rate | phase_reg;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: bench/cst_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pack temperature sensing: comparators against both hot limits and cold.
module cst_analog_model (
  input wire logic sys_clk,
  input wire logic signed [7:0] temp_c,
  output logic bat_hot_45,
  output logic bat_hot_60,
  output logic bat_cold
);
  always @(posedge sys_clk) begin
    bat_hot_45 <= temp_c > 8'sh2D;
    bat_hot_60 <= temp_c > 8'sh3C;
    bat_cold <= temp_c < 8'sh00;
  end
endmodule
`default_nettype wire

/* File: bench/cst_charger_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cst_charger_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sleep_state,
  input wire logic charger_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic load_sharing_loop,
  input wire logic thermal_reg_active,
  input wire logic bat_cold,
  input wire logic thermal_shutdown,
  input wire logic charge_on,
  input wire logic fast_charge_on,
  input wire logic thermistor_high_value,
  input wire logic temp_fault,
  input wire logic reduced_current
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence fault_held;
    (bat_cold || thermal_shutdown) [*2];
  endsequence
  sequence ntc_set;
    reg_wr && reg_addr == 4'h1 && !sleep_state && reg_wdata[3];
  endsequence
  chk_temp_fault_set: assert property (fault_held |-> temp_fault)
    else $error("temperature fault missing");
  chk_fault_stops: assert property (temp_fault [*2] |-> !charge_on)
    else $error("charging during temperature fault");
  chk_fast_stops: assert property (temp_fault [*2] |-> !fast_charge_on)
    else $error("fast charge during temperature fault");
  chk_reduce_on: assert property ((load_sharing_loop || thermal_reg_active) [*2] |-> reduced_current)
    else $error("reduced current missing");
  chk_reduce_off: assert property (!(load_sharing_loop || thermal_reg_active) [*2] |-> !reduced_current)
    else $error("reduced current stuck");
  chk_ntc_write: assert property (ntc_set |-> ##2 thermistor_high_value)
    else $error("thermistor select not taken");
  chk_sleep_default: assert property (sleep_state |-> ##2 !thermistor_high_value)
    else $error("config kept in sleep");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_rd: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_restart_rd0: assert property (reg_rd && reg_addr == 4'h1 |=> !reg_rdata[0])
    else $error("restart bit reads one");
  chk_disabled_off: assert property (!charger_enable [*2] |-> !charge_on)
    else $error("charging while disabled");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 0, rst_n = 0, sleep_state = 0, charger_enable = 0, reg_wr = 0, reg_rd = 0;
  logic usb = 0, ac = 0, ls = 0, tr = 0, above = 0, below = 0, term = 0, tsd = 0, rd_q = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire co, fo, thv, tf, rc, h45, h60, cold;
  logic signed [7:0] temp_c = 8'sh19;
  logic [7:0] exp_q[$], msk_q[$];
  logic [31:0] seed = 32'h00003CEA;
  int err_total = 0, checks = 0, t;
  logic f;
  always #10 sys_clk = ~sys_clk;
  cst_charger_ctrl #(.TICK_CYCLES(32'h4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .sleep_state(sleep_state),
    .charger_enable(charger_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_supply_present(usb), .adapter_supply_present(ac),
    .load_sharing_loop(ls), .thermal_reg_active(tr), .bat_above_precharge_exit(above),
    .bat_below_recharge(below), .current_at_term(term), .bat_hot_45(h45), .bat_hot_60(h60),
    .bat_cold(cold), .thermal_shutdown(tsd), .charge_on(co), .fast_charge_on(fo),
    .thermistor_high_value(thv), .temp_fault(tf), .reduced_current(rc));
  cst_analog_model pack (.sys_clk(sys_clk), .temp_c(temp_c), .bat_hot_45(h45), .bat_hot_60(h60), .bat_cold(cold));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    cyc(1);
    reg_wr <= 1'h0;
    cyc(1);
  endtask
  // The expected value is queued here and compared by the read monitor.
  task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    cyc(1);
    reg_rd <= 1'h0;
    cyc(1);
  endtask
  always @(posedge sys_clk) begin
    if (rd_q) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_q <= reg_rd;
  end
  task complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(20000);
    err_total++;
    complete_run;
  end
  initial begin
    cyc(6);
    rst_n <= 1'h1;
    cyc(2);
    charger_enable <= 1'h1;
    rd(4'h1, 8'h04, 8'hFF);
    rd(4'h2, 8'h01, 8'hFF);
    rd(4'h3, 8'h00, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    wr(4'h1, 8'h0C);
    sleep_state <= 1'h1;
    cyc(1);
    sleep_state <= 1'h0;
    rd(4'h1, 8'h04, 8'hFF);
    usb <= 1'h1;
    cyc(200);
    rd(4'h0, 8'h02, 8'h26);
    for (int i = 0; i < 2; i++) begin
      above <= 1'h0;
      ls <= 1'h1;
      wr(4'h2, i ? 8'h00 : 8'h01);
      if (i) ac <= 1'h1;
      else wr(4'h1, 8'h05);
      cyc(100);
      above <= 1'h1;
      cyc(440);
      rd(4'h0, 8'h00, 8'h04);
      cyc(200);
      rd(4'h0, i ? 8'h04 : 8'h00, 8'h04);
      cyc(400);
      rd(4'h0, 8'h04, 8'h04);
    end
    below <= 1'h1;
    cyc(1);
    below <= 1'h0;
    term <= 1'h1;
    cyc(20);
    rd(4'h0, 8'h00, 8'h05);
    ls <= 1'h0;
    cyc(20);
    rd(4'h0, 8'h01, 8'h01);
    term <= 1'h0;
    wr(4'h1, 8'h05);
    cyc(300);
    temp_c <= -8'sh05;
    cyc(400);
    rd(4'h0, 8'h08, 8'h28);
    temp_c <= 8'sh19;
    cyc(100);
    rd(4'h0, 8'h20, 8'h24);
    cyc(150);
    rd(4'h0, 8'h04, 8'h04);
    repeat (8) begin
      seed = xs(seed);
      t = int'(seed[6:0] % 7'h50) - 10;
      f = t < 0 || t > (seed[8] ? 60 : 45) || seed[9];
      temp_c <= 8'(t);
      tsd <= seed[9];
      ls <= seed[10];
      tr <= seed[11];
      wr(4'h3, {7'h00, seed[8]});
      cyc(3);
      rd(4'h0, {4'h0, f, 3'h0}, 8'h08);
    end
    temp_c <= 8'sh19;
    tsd <= 1'h0;
    ls <= 1'h0;
    tr <= 1'h0;
    term <= 1'h1;
    wr(4'h1, 8'h03);
    cyc(600);
    rd(4'h0, 8'hA0, 8'hE7);
    term <= 1'h0;
    wr(4'h1, 8'h15);
    cyc(600);
    rd(4'h0, 8'hA0, 8'hE4);
    cyc(200);
    rd(4'h0, 8'hC4, 8'hE4);
    complete_run;
  end
endmodule
bind cst_charger_ctrl cst_charger_sva chk (.*);
`default_nettype wire
